// >>> core/acr_regs.v
// Configuration and calibration register bank of a delta-sigma converter
// Functional notes
// - Bit 7 of rate/filter config: 0 pulse alignment, 1 continuous alignment.
// - Bit 6 selects high-resolution mode, set after reset.
// - Bits 5:3 choose data rate 250 to 4000 samples per second.
// - Bit 2 chooses linear (0) or minimum (1) FIR phase.
// - Bits 1:0 choose bypass, sinc, sinc+lowpass, or plus highpass.
// - Routing bits 6:4 pick input pair, shorts or tied pairs.
// - Routing bit 3 enables amplifier chopping, on by default.
// - Routing bits 2:0 set amplifier gain 1 to 64.
// - Highpass corner word is low byte then high byte.
// - Output equals (result minus offset) times gain over 400000h.
// - Correction words load from host writes or calibration commands.
// - Bypass and sinc-only paths skip offset and gain correction.
// - Offset is 24-bit signed, left-aligned to 32-bit data.
// - One offset step equals 256 output codes.
// - Gain word is unsigned with unity at 400000h.
// - Correction bytes stored low, mid, high at rising addresses.
// - Any register write restarts conversion, losing 63 readings.
// - Offset calibration averages 16 readings, gain correction bypassed.
`include "acr_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module acr_regs (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Register access from the command decoder
   input  wire        register_write_cmd,
   input  wire        register_read_cmd,
   input  wire [3:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   output reg         reg_rvalid,
   // Calibration commands
   input  wire        auto_offset_calibrate_cmd,
   input  wire        auto_gain_calibrate_cmd,
   input  wire [23:0] gain_cal_value,
   // Filter result stream
   input  wire        filt_valid,
   input  wire [31:0] filt_result,
   // Scaled output
   output reg         out_valid,
   output reg  [31:0] out_code,
   // Decoded settings
   output reg         continuous_sync,
   output reg         high_resolution,
   output reg  [2:0]  output_rate_select,
   output reg         minimum_phase,
   output reg  [1:0]  filter_path_select,
   output reg  [2:0]  input_routing,
   output reg         amplifier_chopping_enable,
   output reg  [2:0]  input_amplifier_gain,
   output reg  [15:0] highpass_stage_corner,
   output reg         converter_restart,
   output reg         calibrating
);
   // ****************************************
   // Register storage
   // ****************************************
   reg  [7:0]  rate_filter_config;
   reg  [7:0]  input_routing_gain_config;
   reg  [7:0]  highpass_corner_low;
   reg  [7:0]  highpass_corner_high;
   reg  [7:0]  offset_correction_low;
   reg  [7:0]  offset_correction_mid;
   reg  [7:0]  offset_correction_high;
   reg  [7:0]  gain_correction_low;
   reg  [7:0]  gain_correction_mid;
   reg  [7:0]  gain_correction_high;
   reg  [6:0]  discard_count;
   reg  [7:0]  next_rdata;
   wire [23:0] offset_correction_word;
   wire [23:0] gain_correction_word;
   wire [31:0] scaled;
   wire        cal_done;
   wire [23:0] cal_average;
   wire        cal_busy;

   assign offset_correction_word = {offset_correction_high, offset_correction_mid,
                                    offset_correction_low};
   assign gain_correction_word   = {gain_correction_high, gain_correction_mid,
                                    gain_correction_low};

   // ****************************************
   // Register writes and calibration loads
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         rate_filter_config        <= `ACR_RST_RATE_FILTER;
         input_routing_gain_config <= `ACR_RST_ROUTING_GAIN;
         highpass_corner_low       <= `ACR_RST_HP_LOW;
         highpass_corner_high      <= `ACR_RST_HP_HIGH;
         offset_correction_low     <= `ACR_RST_OFS;
         offset_correction_mid     <= `ACR_RST_OFS;
         offset_correction_high    <= `ACR_RST_OFS;
         gain_correction_low       <= `ACR_RST_GAIN_LOW;
         gain_correction_mid       <= `ACR_RST_GAIN_MID;
         gain_correction_high      <= `ACR_RST_GAIN_HIGH;
      end else begin
         if (register_write_cmd) begin
            case (reg_addr)
               `ACR_ADDR_RATE_FILTER:  rate_filter_config <= reg_wdata;
               // Top bit is reserved and held at zero
               `ACR_ADDR_ROUTING_GAIN: input_routing_gain_config <= {1'b0, reg_wdata[6:0]};
               `ACR_ADDR_HP_LOW:       highpass_corner_low <= reg_wdata;
               `ACR_ADDR_HP_HIGH:      highpass_corner_high <= reg_wdata;
               `ACR_ADDR_OFS_LOW:      offset_correction_low <= reg_wdata;
               `ACR_ADDR_OFS_MID:      offset_correction_mid <= reg_wdata;
               `ACR_ADDR_OFS_HIGH:     offset_correction_high <= reg_wdata;
               `ACR_ADDR_GAIN_LOW:     gain_correction_low <= reg_wdata;
               `ACR_ADDR_GAIN_MID:     gain_correction_mid <= reg_wdata;
               `ACR_ADDR_GAIN_HIGH:    gain_correction_high <= reg_wdata;
               default: begin
               end
            endcase
         end
         // Calibration result wins over a host write in the same cycle
         if (cal_done) begin
            {offset_correction_high, offset_correction_mid,
             offset_correction_low} <= cal_average;
         end
         if (auto_gain_calibrate_cmd) begin
            {gain_correction_high, gain_correction_mid,
             gain_correction_low} <= gain_cal_value;
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always @* begin
      case (reg_addr)
         `ACR_ADDR_RATE_FILTER:  next_rdata = rate_filter_config;
         `ACR_ADDR_ROUTING_GAIN: next_rdata = input_routing_gain_config;
         `ACR_ADDR_HP_LOW:       next_rdata = highpass_corner_low;
         `ACR_ADDR_HP_HIGH:      next_rdata = highpass_corner_high;
         `ACR_ADDR_OFS_LOW:      next_rdata = offset_correction_low;
         `ACR_ADDR_OFS_MID:      next_rdata = offset_correction_mid;
         `ACR_ADDR_OFS_HIGH:     next_rdata = offset_correction_high;
         `ACR_ADDR_GAIN_LOW:     next_rdata = gain_correction_low;
         `ACR_ADDR_GAIN_MID:     next_rdata = gain_correction_mid;
         `ACR_ADDR_GAIN_HIGH:    next_rdata = gain_correction_high;
         default:                next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= register_read_cmd;
         if (register_read_cmd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ****************************************
   // Decoded settings
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         continuous_sync           <= 1'b0;
         high_resolution           <= 1'b1;
         output_rate_select        <= 3'h2;
         minimum_phase             <= 1'b0;
         filter_path_select        <= 2'h2;
         input_routing             <= 3'h0;
         amplifier_chopping_enable <= 1'b1;
         input_amplifier_gain      <= 3'h0;
         highpass_stage_corner     <= 16'h0332;
      end else begin
         continuous_sync           <= rate_filter_config[`ACR_BIT_SYNC_MODE];
         high_resolution           <= rate_filter_config[`ACR_BIT_HIRES];
         output_rate_select        <= rate_filter_config[`ACR_RATE_HI:`ACR_RATE_LO];
         minimum_phase             <= rate_filter_config[`ACR_BIT_MIN_PHASE];
         filter_path_select        <= rate_filter_config[1:0];
         input_routing             <= input_routing_gain_config[`ACR_ROUTE_HI:`ACR_ROUTE_LO];
         amplifier_chopping_enable <= input_routing_gain_config[`ACR_BIT_AMPLIFIER_CHOPPING_ENABLE];
         input_amplifier_gain      <= input_routing_gain_config[2:0];
         highpass_stage_corner     <= {highpass_corner_high, highpass_corner_low};
      end
   end

   // ****************************************
   // Restart after register write
   // ****************************************
   // Readings are suppressed while the filters refill
   always @(posedge clk) begin
      if (rst) begin
         discard_count     <= 7'h00;
         converter_restart <= 1'b0;
      end else begin
         converter_restart <= register_write_cmd;
         if (register_write_cmd) begin
            discard_count <= `ACR_RESTART_READINGS;
         end else if (filt_valid && discard_count != 7'h00) begin
            discard_count <= discard_count - 7'h01;
         end
      end
   end

   // ****************************************
   // Offset calibration and scaling
   // ****************************************
   acr_avg16 u_avg (
      .clk          (clk),
      .rst          (rst),
      .start        (auto_offset_calibrate_cmd),
      .sample_valid (filt_valid && discard_count == 7'h00),
      .sample       (filt_result),
      .done         (cal_done),
      .average      (cal_average),
      .busy         (cal_busy)
   );

   // Averaging runs on raw filter data, so correction stays out of its way
   acr_scaler u_scale (
      .filt_result (filt_result),
      .offset_word (cal_busy ? 24'h00_0000 : offset_correction_word),
      .gain_word   (cal_busy ? `ACR_GAIN_UNITY : gain_correction_word),
      .gain_bypass (1'b0),
      .scaled      (scaled)
   );

   always @(posedge clk) begin
      if (rst) begin
         out_valid   <= 1'b0;
         out_code    <= 32'h0000_0000;
         calibrating <= 1'b0;
      end else begin
         calibrating <= cal_busy;
         out_valid   <= filt_valid && discard_count == 7'h00 && !register_write_cmd;
         if (filt_valid) begin
            if (filter_path_select == `ACR_FILT_SINC || filter_path_select == `ACR_FILT_BYPASS) begin
               out_code <= filt_result;
            end else begin
               out_code <= scaled;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/acr_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
`define ACR_ADDR_RATE_FILTER   4'h1
`define ACR_ADDR_ROUTING_GAIN  4'h2
`define ACR_ADDR_HP_LOW        4'h3
`define ACR_ADDR_HP_HIGH       4'h4
`define ACR_ADDR_OFS_LOW       4'h5
`define ACR_ADDR_OFS_MID       4'h6
`define ACR_ADDR_OFS_HIGH      4'h7
`define ACR_ADDR_GAIN_LOW      4'h8
`define ACR_ADDR_GAIN_MID      4'h9
`define ACR_ADDR_GAIN_HIGH     4'ha
`define ACR_RST_RATE_FILTER    8'h52
`define ACR_RST_ROUTING_GAIN   8'h08
`define ACR_RST_HP_LOW         8'h32
`define ACR_RST_HP_HIGH        8'h03
`define ACR_RST_OFS            8'h00
`define ACR_RST_GAIN_LOW       8'h00
`define ACR_RST_GAIN_MID       8'h00
`define ACR_RST_GAIN_HIGH      8'h40
`define ACR_BIT_SYNC_MODE      7
`define ACR_BIT_HIRES          6
`define ACR_RATE_HI            5
`define ACR_RATE_LO            3
`define ACR_BIT_MIN_PHASE      2
`define ACR_BIT_AMPLIFIER_CHOPPING_ENABLE           3
`define ACR_ROUTE_HI           6
`define ACR_ROUTE_LO           4
`define ACR_FILT_BYPASS        2'b00
`define ACR_FILT_SINC          2'b01
`define ACR_RESTART_READINGS   7'h3f
`define ACR_CAL_READINGS       5'h10
`define ACR_GAIN_UNITY         24'h40_0000
`endif

// >>> core/acr_scaler.v
// Offset subtract, gain multiply and saturation of one conversion result
`timescale 1ns/1ns
`default_nettype none
module acr_scaler (
   // Operands
   input  wire signed [31:0] filt_result,
   input  wire        [23:0] offset_word,
   input  wire        [23:0] gain_word,
   input  wire               gain_bypass,
   // Result
   output wire        [31:0] scaled
);
   wire signed [33:0] diff;
   wire signed [58:0] prod;
   wire signed [36:0] quot;
   wire signed [36:0] pick;
   // Offset is left-aligned: one step is 256 output codes
   assign diff = {{2{filt_result[31]}}, filt_result} - {{2{offset_word[23]}}, offset_word, 8'h00};
   assign prod = diff * $signed({1'b0, gain_word});
   // Divide by unity code 400000h
   assign quot = prod[58:22];
   assign pick = gain_bypass ? {{3{diff[33]}}, diff} : quot;
   // Clamp instead of wrapping
   assign scaled = (pick > 37'sh0_7fff_ffff) ? 32'h7fff_ffff :
                   (pick < -37'sh0_8000_0000) ? 32'h8000_0000 : pick[31:0];
endmodule
`default_nettype wire

// >>> core/acr_avg16.v
// Accumulator that averages sixteen readings for offset calibration
`include "acr_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module acr_avg16 (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Control
   input  wire        start,
   input  wire        sample_valid,
   input  wire [31:0] sample,
   // Result
   output reg         done,
   output reg  [23:0] average,
   output reg         busy
);
   reg signed [35:0] acc;
   reg        [4:0]  count;
   wire signed [35:0] next_acc;
   assign next_acc = acc + {{4{sample[31]}}, sample};
   always @(posedge clk) begin
      if (rst) begin
         acc     <= 36'h0_0000_0000;
         count   <= 5'h00;
         done    <= 1'b0;
         average <= 24'h00_0000;
         busy    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            acc   <= 36'h0_0000_0000;
            count <= 5'h00;
            busy  <= 1'b1;
         end else if (busy && sample_valid) begin
            acc   <= next_acc;
            count <= count + 5'h01;
            if (count == `ACR_CAL_READINGS - 5'h01) begin
               busy    <= 1'b0;
               done    <= 1'b1;
               // Mean of 16, then keep the top 24 bits to match offset alignment
               average <= next_acc[35:12];
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/acr_regs_assertions.sv
// Port-level checks of the register bank
`timescale 1ns/1ns
`default_nettype none
module acr_regs_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register access and calibration
   input wire logic        register_write_cmd,
   input wire logic        register_read_cmd,
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        auto_offset_calibrate_cmd,
   input wire logic        calibrating,
   input wire logic        converter_restart,
   // Data path
   input wire logic        filt_valid,
   input wire logic [31:0] filt_result,
   input wire logic        out_valid,
   input wire logic [31:0] out_code,
   // Decoded settings
   input wire logic        continuous_sync,
   input wire logic        high_resolution,
   input wire logic [2:0]  output_rate_select,
   input wire logic        minimum_phase,
   input wire logic [1:0]  filter_path_select,
   input wire logic [2:0]  input_routing,
   input wire logic        amplifier_chopping_enable,
   input wire logic [2:0]  input_amplifier_gain,
   input wire logic [15:0] highpass_stage_corner
);
   logic [6:0] since_wr;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // All ones until the first write, so the restart checks stay idle after reset
   always @(posedge clk) begin
      if (rst)
         since_wr <= 7'h7f;
      else if (register_write_cmd)
         since_wr <= 7'h00;
      else if (filt_valid && since_wr < 7'h3f)
         since_wr <= since_wr + 7'h01;
   end
   a_cfg0_decode: assert property (
      register_write_cmd && reg_addr == 4'h1 |-> ##2 {continuous_sync, high_resolution,
      output_rate_select, minimum_phase, filter_path_select} == $past(reg_wdata, 2))
      else $error("rate and filter settings wrong");
   a_cfg1_decode: assert property (
      register_write_cmd && reg_addr == 4'h2 |-> ##2 {input_routing,
      amplifier_chopping_enable, input_amplifier_gain} == $past(reg_wdata[6:0], 2))
      else $error("routing and gain settings wrong");
   a_corner_high: assert property (
      register_write_cmd && reg_addr == 4'h4 |-> ##2
      highpass_stage_corner[15:8] == $past(reg_wdata, 2))
      else $error("corner high byte wrong");
   a_restart_pulse: assert property (register_write_cmd |=> converter_restart)
      else $error("no restart after write");
   a_restart_block: assert property (
      filt_valid && !register_write_cmd && since_wr < 7'h3f |=> !out_valid)
      else $error("output during restart");
   a_restart_resume: assert property (
      filt_valid && !register_write_cmd && since_wr == 7'h3f |=> out_valid)
      else $error("output missing after restart");
   a_sinc_raw: assert property (
      filt_valid && since_wr == 7'h3f && filter_path_select == 2'b01 |=>
      out_code == $past(filt_result))
      else $error("sinc path output scaled");
   a_cal_start: assert property (auto_offset_calibrate_cmd |-> ##2 calibrating)
      else $error("calibration did not start");
   a_cal_bypass: assert property (
      calibrating && filt_valid && since_wr == 7'h3f |=> out_code == $past(filt_result))
      else $error("correction applied while calibrating");
   a_reserved_bit: assert property (
      register_read_cmd && reg_addr == 4'h2 |=> reg_rvalid && !reg_rdata[7])
      else $error("reserved routing bit stored");
endmodule
bind acr_regs acr_regs_checker acr_regs_checker_i (.*);
`default_nettype wire

// >>> tb/acr_host.sv
// Host controller issuing register read and write commands
`timescale 1ns/1ns
`default_nettype none
module acr_host (
   // Clock
   input  wire logic       clk,
   // Commands
   output var  logic       register_write_cmd,
   output var  logic       register_read_cmd,
   output var  logic [3:0] reg_addr,
   output var  logic [7:0] reg_wdata
);
   initial begin
      register_write_cmd = 1'b0;
      register_read_cmd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
   end
   // Idle address and data lines show the inverse so stale values are never mistaken for a request
   task automatic cmd(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      register_write_cmd = w;
      register_read_cmd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      register_write_cmd = 1'b0;
      register_read_cmd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// >>> tb/acr_regs_test.sv
// Self-checking bench for the configuration and calibration register bank
`timescale 1ns/1ns
`default_nettype none
module acr_regs_test;
   logic clk = 1'b0, rst = 1'b1, filt_valid = 1'b0, ofs_cal = 1'b0, gain_cal = 1'b0;
   logic [31:0] filt_result = 32'h0000_0000;
   logic [23:0] gain_cal_value = 24'h00_0000, ofs = 24'h00_0000, gain = 24'h40_0000;
   logic [1:0]  path = 2'b10;
   wire logic [7:0]  cfg0, wdata, rdata;
   wire logic [6:0]  cfg1;
   wire logic [15:0] corner;
   wire logic [3:0]  addr;
   wire logic [31:0] out_code;
   wire logic        wr_cmd, rd_cmd, rvalid, out_valid, restart, calibrating;
   logic [31:0] rq[$], oq[$];
   int          mismatches = 0, comparisons = 0, cycles = 0;
   integer      seed = 32'h0000_44c8;
   logic [7:0]  rstv [16] = '{8'h00, 8'h52, 8'h08, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [23:0] ofs_tab [5] = '{24'h00_0001, 24'hff_ffff, 24'h12_3456, 24'h80_0000, 24'h7f_ffff};
   logic [23:0] gain_tab [5] = '{24'h40_0000, 24'h40_0000, 24'h80_0000, 24'h20_0000, 24'h00_0000};
   acr_host acr_host_i (.clk(clk), .register_write_cmd(wr_cmd), .register_read_cmd(rd_cmd),
      .reg_addr(addr), .reg_wdata(wdata));
   acr_regs acr_regs_i (.clk(clk), .rst(rst), .register_write_cmd(wr_cmd),
      .register_read_cmd(rd_cmd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .auto_offset_calibrate_cmd(ofs_cal),
      .auto_gain_calibrate_cmd(gain_cal), .gain_cal_value(gain_cal_value),
      .filt_valid(filt_valid), .filt_result(filt_result), .out_valid(out_valid),
      .out_code(out_code), .continuous_sync(cfg0[7]), .high_resolution(cfg0[6]),
      .output_rate_select(cfg0[5:3]), .minimum_phase(cfg0[2]), .filter_path_select(cfg0[1:0]),
      .input_routing(cfg1[6:4]), .amplifier_chopping_enable(cfg1[3]),
      .input_amplifier_gain(cfg1[2:0]), .highpass_stage_corner(corner),
      .converter_restart(restart), .calibrating(calibrating));
   task automatic conclude;
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] scale(input logic [31:0] x);
      logic signed [63:0] p;
      p = ($signed({{32{x[31]}}, x}) - $signed({{32{ofs[23]}}, ofs, 8'h00}))
          * $signed({40'h00_0000_0000, gain}) >>> 22;
      if (path < 2'b10)
         return x;
      if (p > 64'sh7fff_ffff)
         return 32'h7fff_ffff;
      if (p < -64'sh8000_0000)
         return 32'h8000_0000;
      return p[31:0];
   endfunction
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(32'(e));
      acr_host_i.cmd(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acr_host_i.cmd(1'b1, a, d);
      check(32'(restart), 32'h0000_0001);
   endtask
   task automatic setw(input logic [3:0] a, input logic [23:0] w);
      wr(a, w[7:0]);
      wr(a + 4'h1, w[15:8]);
      wr(a + 4'h2, w[23:16]);
   endtask
   // Every fourth reading is zero so offset steps show up exactly
   task automatic run(input int n, input bit note);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         filt_valid = 1'b1;
         filt_result = (i % 4 == 3) ? 32'h0000_0000 : $random(seed);
         if (note)
            oq.push_back(scale(filt_result));
         @(negedge clk);
         filt_valid = 1'b0;
      end
   endtask
   task automatic rdall;
      for (int a = 0; a < 16; a++)
         rd(4'(a), rstv[a]);
   endtask
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   // ****************************************
   // Result watcher
   // ****************************************
   always @(negedge clk) begin
      if (rvalid === 1'b1)
         check(32'(rdata), rq.size() > 0 ? rq.pop_front() : 32'h0000_0100);
      if (out_valid === 1'b1 && oq.size() == 0)
         check(32'h0000_0001, 32'h0000_0000);
      else if (out_valid === 1'b1)
         check(out_code, oq.pop_front());
   end
   initial begin
      logic [7:0]  d;
      logic [35:0] sum;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rdall();
      check(32'(cfg0), 32'h0000_0052);
      check(32'(cfg1), 32'h0000_0008);
      check(32'(corner), 32'h0000_0332);
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         d[5:3] = 3'(i % 5);
         d[1:0] = 2'(i);
         wr(4'h1, d);
         @(negedge clk);
         check(32'(cfg0), 32'(d));
         d = $random(seed);
         d[6:4] = 3'(i % 5);
         d[2:0] = 3'(i % 7);
         wr(4'h2, d);
         @(negedge clk);
         check(32'(cfg1), 32'(d[6:0]));
         rd(4'h2, {1'b0, d[6:0]});
      end
      for (int a = 3; a < 16; a++) begin
         d = $random(seed);
         wr(4'(a), d);
         rd(4'(a), a > 10 ? 8'h00 : d);
      end
      wr(4'h3, 8'h5a);
      wr(4'h4, 8'hc3);
      @(negedge clk);
      check(32'(corner), 32'h0000_c35a);
      for (int k = 0; k < 9; k++) begin
         ofs = ofs_tab[k % 5];
         gain = gain_tab[k % 5];
         path = k < 5 ? 2'b10 : 2'(k - 5);
         setw(4'h5, ofs);
         setw(4'h8, gain);
         wr(4'h1, {6'h14, path});
         run(63, 1'b0);
         run(6, 1'b1);
      end
      wr(4'h2, 8'h0e);
      run(63, 1'b0);
      ofs = 24'h00_0000;
      gain = 24'h40_0000;
      @(negedge clk);
      ofs_cal = 1'b1;
      @(negedge clk);
      ofs_cal = 1'b0;
      sum = 36'h0_0000_0000;
      for (int i = 0; i < 16; i++) begin
         run(1, 1'b1);
         sum = sum + {{4{filt_result[31]}}, filt_result};
      end
      for (int n = 0; n < 8 && calibrating !== 1'b0; n++)
         @(negedge clk);
      check(32'(calibrating), 32'h0000_0000);
      rd(4'h5, sum[19:12]);
      rd(4'h6, sum[27:20]);
      rd(4'h7, sum[35:28]);
      ofs = sum[35:12];
      gain = 24'h20_0000;
      run(4, 1'b1);
      @(negedge clk);
      gain_cal_value = 24'($random(seed));
      gain_cal = 1'b1;
      @(negedge clk);
      gain_cal = 1'b0;
      gain = gain_cal_value;
      rd(4'h8, gain[7:0]);
      rd(4'h9, gain[15:8]);
      rd(4'ha, gain[23:16]);
      run(4, 1'b1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rdall();
      @(negedge clk);
      check(32'(oq.size() + rq.size()), 32'h0000_0000);
      conclude();
   end
endmodule
`default_nettype wire
